//--- design/edsp_pkg.sv
// Purpose: Constants and carrier types for the extended data space pager
// Assumes: Single 200 MHz instruction clock, synchronous inputs
// Notes: Overview of operation follows
// Overview of operation
// - Extended space is split into 32 Kbyte pages; read and write pages.
// - Program window reads use the read page only, never the write page.
// - Page value joins 16-bit core address into a 24-bit address.
// - Read, bit 15 set, read page bit 9 clear: page[8:0] over addr[14:0].
// - Write with bit 15 set: write page[8:0] over addr[14:0].
// - Bit 15 set with page zero raises an address error, no access.
// - Addresses below 8000h ignore pages and map straight through.
// - Near region 0000h-1FFFh reachable by indirect and direct modes.
// - Page registers never change on pointer rollover; software does it.
// - Extended reads add one cycle, two cycles minimum.
// - Repeated extended reads: first two take three cycles, then one.
// - Extended writes complete in one cycle with no overhead.
// - Extended space covers extra internal RAM and parallel port memory.
// - 32K internal RAM; external up to 16 Mbytes or 64K by variant. Small variant here traps every external access.
// - Read, bit 15 set, read page bit 9 set: goes to program window.
// - Read page register is 10 bits wide.
`default_nettype none
package edsp_pkg;
    localparam int EDSP_AW = 16;
    localparam int EDSP_XW = 24;
    localparam int EDSP_RPW = 10;
    localparam int EDSP_WPW = 9;
    localparam int EDSP_PSW = 23;
    localparam logic [3:0] EDSP_OFF_RPAGE = 4'h0;
    localparam logic [3:0] EDSP_OFF_WPAGE = 4'h1;
    localparam logic [3:0] EDSP_OFF_STAT = 4'h2;
    localparam logic [3:0] EDSP_OFF_MASK = 4'h3;
    localparam logic [3:0] EDSP_OFF_VAR = 4'h4;
    localparam logic [9:0] EDSP_RPAGE_RST = 10'h001;
    localparam logic [8:0] EDSP_WPAGE_RST = 9'h001;
    localparam logic [15:0] EDSP_NEAR_TOP = 16'h1fff;
    localparam int EDSP_WIN_BIT = 15;
    localparam int EDSP_PROG_BIT = 9;
    localparam int EDSP_HALF_BIT = 8;
    localparam int EDSP_RD_CYC = 2;
    localparam int EDSP_RPT_FIRST_CYC = 3;
    localparam int EDSP_RPT_NEXT_CYC = 1;
    localparam int EDSP_WR_CYC = 1;
    localparam int EDSP_RPT_FIRST_N = 2;
    localparam logic [23:0] EDSP_EXT_MAX_BIG = 24'hffffff;
    localparam logic [23:0] EDSP_EXT_MAX_SMALL = 24'h00ffff;
    localparam logic [23:0] EDSP_INT_TOP = 24'h00ffff;
    localparam int EDSP_ST_ERR = 0;
    localparam int EDSP_ST_RANGE = 1;
    typedef enum logic [1:0] {EDSP_TGT_DATA, EDSP_TGT_EXT, EDSP_TGT_PROG,
                              EDSP_TGT_NONE} edsp_tgt_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic rpt;
        logic direct;
        logic [15:0] addr;
    } edsp_req_t;
    typedef struct packed {
        logic valid;
        logic wr;
        edsp_tgt_t tgt;
        logic [23:0] xaddr;
        logic hi_word;
    } edsp_mem_t;
endpackage
`default_nettype wire

//--- design/edsp_top.sv
// Purpose: Forms 24-bit extended addresses from page registers and core EA
// Assumes: One request at a time; requester holds it until done pulses
// Notes: Near direct addresses above the near region are flagged as errors
//
// Added by the designer: the placing of the registers and the plain strobed port.
`default_nettype none
module edsp_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Variant strap, high for large external memory
    input wire logic big_variant,
    // Core request
    input wire edsp_pkg::edsp_req_t req,
    output logic busy,
    output logic done,
    output logic addr_err_trap,
    // Memory side
    output edsp_pkg::edsp_mem_t mem,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Interrupt
    output logic irq
);
    import edsp_pkg::*;

    typedef enum {EDSP_IDLE, EDSP_WAIT} edsp_st_t;

    logic rst_s1_r, rst_s2_r;
    logic [9:0] rpage_r;
    logic [8:0] wpage_r;
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] mask_r;
    logic big_r, strap_done_r;
    edsp_st_t st_r;
    logic [1:0] wait_r;
    logic first_n_r;
    logic [1:0] rpt_cnt_r;
    logic win, prog_win, page_zero, near_bad, range_bad, err, start;
    logic [23:0] xaddr;
    logic [23:0] ext_max;
    edsp_tgt_t tgt;
    logic [1:0] lat;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Strap captured once after reset release
    always_ff @(posedge clock or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            big_r <= 1'b1;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            big_r <= big_variant;
            strap_done_r <= 1'b1;
        end
    end

    // Address formation
    always_comb begin
        win = req.addr[EDSP_WIN_BIT];
        prog_win = req.rd && rpage_r[EDSP_PROG_BIT];
        page_zero = req.rd ? (rpage_r == 10'h000) : (wpage_r == 9'h000);
        near_bad = req.direct && (req.addr > EDSP_NEAR_TOP);
        ext_max = big_r ? EDSP_EXT_MAX_BIG : EDSP_EXT_MAX_SMALL;
        xaddr = {8'h00, req.addr};
        tgt = EDSP_TGT_DATA;
        if (win) begin
            if (req.wr) begin
                xaddr = {wpage_r, req.addr[14:0]};
            end else if (prog_win) begin
                xaddr = {1'b0, rpage_r[7:0], req.addr[14:0]};
            end else begin
                xaddr = {rpage_r[8:0], req.addr[14:0]};
            end
            if (prog_win && !req.wr) begin
                tgt = EDSP_TGT_PROG;
            end else if (xaddr > EDSP_INT_TOP) begin
                tgt = EDSP_TGT_EXT;
            end else begin
                tgt = EDSP_TGT_DATA;
            end
        end
        range_bad = win && (tgt == EDSP_TGT_EXT) && (xaddr > ext_max);
        err = (win && page_zero) || near_bad || range_bad;
        // A held single request is not taken twice; repeats chain on done
        start = (st_r == EDSP_IDLE) && (req.rd || req.wr) &&
                !(done && !req.rpt);
        if (!req.wr && win) begin
            if (req.rpt && first_n_r) begin
                lat = 2'(EDSP_RPT_FIRST_CYC - 1);
            end else if (req.rpt) begin
                lat = 2'(EDSP_RPT_NEXT_CYC - 1);
            end else begin
                lat = 2'(EDSP_RD_CYC - 1);
            end
        end else begin
            lat = 2'(EDSP_WR_CYC - 1);
        end
    end

    // Page registers change only on software writes
    always_ff @(posedge clock or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            rpage_r <= EDSP_RPAGE_RST;
            wpage_r <= EDSP_WPAGE_RST;
            mask_r <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == EDSP_OFF_RPAGE) begin
                rpage_r <= reg_wdata[EDSP_RPW-1:0];
            end
            if (reg_addr == EDSP_OFF_WPAGE) begin
                wpage_r <= reg_wdata[EDSP_WPW-1:0];
            end
            if (reg_addr == EDSP_OFF_MASK) begin
                mask_r <= reg_wdata[1:0];
            end
        end
    end

    // Sticky status, set beats write-one clear
    always_comb begin
        stat_nxt = stat_r;
        if (reg_wr && reg_addr == EDSP_OFF_STAT) begin
            stat_nxt = stat_r & ~reg_wdata[1:0];
        end
        if (start && err) begin
            stat_nxt[EDSP_ST_ERR] = 1'b1;
        end
        if (start && range_bad) begin
            stat_nxt[EDSP_ST_RANGE] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            stat_r <= 2'h0;
            irq <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq <= |(stat_nxt & mask_r);
        end
    end

    always_ff @(posedge clock or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                EDSP_OFF_RPAGE: reg_rdata <= {6'h00, rpage_r};
                EDSP_OFF_WPAGE: reg_rdata <= {7'h00, wpage_r};
                EDSP_OFF_STAT: reg_rdata <= {14'h0000, stat_r};
                EDSP_OFF_MASK: reg_rdata <= {14'h0000, mask_r};
                EDSP_OFF_VAR: reg_rdata <= {15'h0000, big_r};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Repeat tracking: first two extended reads of a run are slow
    always_ff @(posedge clock or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            rpt_cnt_r <= 2'h0;
        end else if (!req.rpt) begin
            rpt_cnt_r <= 2'h0;
        end else if (start && !req.wr && win && !err &&
                     rpt_cnt_r != 2'(EDSP_RPT_FIRST_N)) begin
            rpt_cnt_r <= rpt_cnt_r + 2'h1;
        end
    end
    assign first_n_r = rpt_cnt_r != 2'(EDSP_RPT_FIRST_N);

    // Access sequencer
    always_ff @(posedge clock or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            st_r <= EDSP_IDLE;
            wait_r <= 2'h0;
            busy <= 1'b0;
            done <= 1'b0;
            addr_err_trap <= 1'b0;
            mem <= '0;
        end else begin
            done <= 1'b0;
            addr_err_trap <= 1'b0;
            mem.valid <= 1'b0;
            case (st_r)
                EDSP_IDLE: begin
                    if (start && err) begin
                        addr_err_trap <= 1'b1;
                        done <= 1'b1;
                    end else if (start) begin
                        mem.valid <= 1'b1;
                        mem.wr <= req.wr;
                        mem.tgt <= tgt;
                        mem.xaddr <= xaddr;
                        mem.hi_word <= prog_win && rpage_r[EDSP_HALF_BIT];
                        if (lat == 2'h0) begin
                            done <= 1'b1;
                        end else begin
                            wait_r <= lat - 2'h1;
                            busy <= 1'b1;
                            st_r <= EDSP_WAIT;
                        end
                    end
                end
                EDSP_WAIT: begin
                    if (wait_r == 2'h0) begin
                        done <= 1'b1;
                        busy <= 1'b0;
                        st_r <= EDSP_IDLE;
                    end else begin
                        wait_r <= wait_r - 2'h1;
                    end
                end
                default: st_r <= EDSP_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- sim/edsp_assertions.sv
// Purpose: Port checks for the extended space pager
// Assumes: Sees only ports of edsp_top
// Notes: Bound at the foot of this file
`default_nettype none
module edsp_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Core side
    input wire edsp_pkg::edsp_req_t req,
    input wire logic busy,
    input wire logic done,
    input wire logic addr_err_trap,
    // Memory side
    input wire edsp_pkg::edsp_mem_t mem
);
    import edsp_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    trap_has_done_a: assert property (addr_err_trap |-> done)
        else $error("trap without done");
    trap_no_mem_a: assert property (addr_err_trap |-> !mem.valid)
        else $error("memory access on trap");
    wr_single_a: assert property (mem.valid && mem.wr |-> done && !busy)
        else $error("write not single cycle");
    ext_rd_two_a: assert property (req.rd && req.addr[15] && !req.rpt &&
        !$past(req.rpt) && mem.valid |-> busy ##1 (done && !busy))
        else $error("extended read not two cycles");
    near_map_a: assert property (mem.valid && !req.addr[15] |->
        mem.xaddr == {8'h00, req.addr} && mem.tgt == EDSP_TGT_DATA)
        else $error("near address not direct");
    wr_map_a: assert property (mem.valid && mem.wr && req.addr[15] |->
        mem.xaddr[14:0] == req.addr[14:0] && mem.tgt != EDSP_TGT_PROG)
        else $error("write offset wrong");
    rd_map_a: assert property (mem.valid && !mem.wr && req.addr[15] |->
        mem.xaddr[14:0] == req.addr[14:0])
        else $error("read offset wrong");
    prog_map_a: assert property (mem.valid && mem.tgt == EDSP_TGT_PROG |->
        !mem.wr && !mem.xaddr[23])
        else $error("program window misuse");
    direct_trap_a: assert property (req.direct && req.rd &&
        req.addr > EDSP_NEAR_TOP && !busy && !done |=> addr_err_trap)
        else $error("far direct address not trapped");
    cover property (addr_err_trap);
    cover property (mem.valid && mem.tgt == EDSP_TGT_PROG);
    cover property (req.rpt && done ##1 done);
endmodule
bind edsp_top edsp_assertions u_chk (.clock(clock), .rst_b(rst_b),
    .req(req), .busy(busy), .done(done), .addr_err_trap(addr_err_trap),
    .mem(mem));
`default_nettype wire

//--- sim/edsp_core_model.sv
// Purpose: Core address unit stand-in that issues requests
// Assumes: Request held until the last done pulse
// Notes: Released address lines show the inverse of the last one
`default_nettype none
module edsp_core_model (
    // Clock
    input wire logic clock,
    // Bench command
    input wire logic go,
    input wire edsp_pkg::edsp_req_t cmd,
    input wire logic [3:0] n,
    // Pager side
    input wire logic done,
    output edsp_pkg::edsp_req_t req
);
    import edsp_pkg::*;
    logic [3:0] left_r = 4'h0;
    initial req = '0;
    always @(posedge clock) begin
        if (go) begin
            req <= cmd;
            req.rpt <= cmd.rpt & cmd.rd;
            left_r <= n;
        end else if (done) begin
            left_r <= left_r - 4'h1;
            // Repeat drops once the last access has started, so its done starts no other
            if (left_r == 4'h2) req.rpt <= 1'b0;
            if (left_r == 4'h1) req <= {4'h0, ~req.addr};
        end
    end
endmodule
`default_nettype wire

//--- sim/test_edsp_top.sv
// Purpose: Self-checking bench for the extended space pager
// Assumes: Both variant straps, register access over plain port
// Notes: Pages and addresses come from an LFSR
`default_nettype none
module test_edsp_top;
    timeunit 1ns;
    timeprecision 1ps;
    import edsp_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected %0t got %h", $time, a); end end
    logic clock = 0, rst_b = 0, go = 0, reg_wr = 0, reg_rd = 0;
    logic big_variant = 1'b1;
    logic busy, done, addr_err_trap, irq;
    logic [3:0] reg_addr = 4'h0, n = 4'h1;
    logic [15:0] reg_wdata = 16'h0, reg_rdata;
    logic [31:0] lfsr = 32'h803d77da;
    edsp_req_t cmd = '0, req;
    edsp_mem_t mem, got;
    int n_fail = 0, cmp_count = 0, cyc = 0, rp = 1, wp = 1;
    always #2.5 clock = ~clock;
    edsp_top dut (.clock(clock), .rst_b(rst_b), .big_variant(big_variant),
        .req(req), .busy(busy), .done(done), .addr_err_trap(addr_err_trap),
        .mem(mem), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    edsp_core_model core (.clock(clock), .go(go), .cmd(cmd), .n(n),
        .done(done), .req(req));
    task automatic finish_test;
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test;
        end
    end
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wreg(logic [3:0] a, logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rreg(logic [3:0] a, logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        `CHK(reg_rdata, e)
    endtask
    task automatic acc(logic w, logic d, logic [15:0] a, int k);
        logic [23:0] x;
        logic [1:0] t;
        logic tr;
        int lat;
        int l;
        x = {8'h00, a};
        tr = d && a > EDSP_NEAR_TOP;
        if (a[15]) begin
            x = w ? {wp[8:0], a[14:0]} : rp[9] ? {1'b0, rp[7:0], a[14:0]}
                : {rp[8:0], a[14:0]};
            tr |= w ? wp == 0 : rp == 0;
        end
        t = (!w && a[15] && rp[9]) ? 2'd2 : {1'b0, x > EDSP_INT_TOP};
        tr |= t == 2'd1 && !big_variant && x > EDSP_EXT_MAX_SMALL;
        cmd <= {~w, w, k > 1, d, a};
        n <= k[3:0];
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        for (int i = 0; i < k; i++) begin
            lat = 0;
            got = '0;
            l = (w || !a[15] || tr) ? 1 : k == 1 ? 2 : i < 2 ? 3 : 1;
            do begin
                @(posedge clock);
                lat++;
                if (mem.valid) got = mem;
            end while (!done && lat < 9);
            `CHK(lat, l + (i == 0))
            `CHK(addr_err_trap, tr)
            `CHK(got.valid, !tr)
            if (!tr) begin
                `CHK(got.xaddr, x)
                `CHK(got.tgt, t)
                `CHK(got.wr, w)
                if (t == 2) `CHK(got.hi_word, rp[8])
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (6) @(posedge clock);
        rreg(EDSP_OFF_RPAGE, 16'h0001);
        rreg(EDSP_OFF_WPAGE, 16'h0001);
        rreg(EDSP_OFF_STAT, 16'h0000);
        rreg(4'hf, 16'h0000);
        rreg(EDSP_OFF_VAR, 16'h0001);
        acc(1'b0, 1'b1, 16'h1fff, 1);
        acc(1'b0, 1'b1, 16'h2000, 1);
        for (int i = 0; i < 40; i++) begin
            lfsr = lfsr_next(lfsr);
            if (i % 6 == 0) lfsr[31:16] = 16'h0;
            if (i % 7 == 0) lfsr[9:0] = 10'h0;
            rp = lfsr[9:0];
            wp = lfsr[24:16];
            wreg(EDSP_OFF_RPAGE, lfsr[15:0]);
            wreg(EDSP_OFF_WPAGE, lfsr[31:16]);
            acc(lfsr[26], lfsr[28], lfsr[15:0] ^ lfsr[31:16], 1);
            acc(lfsr[27], 1'b0, 16'hffff, 1);
            acc(lfsr[25], 1'b0, 16'h8000, 1);
            rreg(EDSP_OFF_RPAGE, rp[15:0]);
            rreg(EDSP_OFF_WPAGE, wp[15:0]);
        end
        wreg(EDSP_OFF_RPAGE, 16'h0005);
        rp = 5;
        acc(1'b0, 1'b0, 16'h8000, 4);
        wreg(EDSP_OFF_WPAGE, 16'h0005);
        wp = 5;
        acc(1'b0, 1'b0, 16'h8123, 1);
        acc(1'b1, 1'b0, 16'h8123, 1);
        wreg(EDSP_OFF_RPAGE, 16'h0000);
        rp = 0;
        acc(1'b0, 1'b0, 16'h8000, 1);
        rreg(EDSP_OFF_STAT, 16'h0001);
        `CHK(irq, 1'b0)
        wreg(EDSP_OFF_MASK, 16'h0001);
        @(posedge clock);
        `CHK(irq, 1'b1)
        wreg(EDSP_OFF_STAT, 16'h0001);
        @(posedge clock);
        `CHK(irq, 1'b0)
        // Second reset with the small variant strap
        rst_b <= 1'b0;
        big_variant <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        rp = 1;
        wp = 1;
        repeat (4) @(posedge clock);
        rreg(EDSP_OFF_VAR, 16'h0000);
        rreg(EDSP_OFF_STAT, 16'h0000);
        acc(1'b1, 1'b0, 16'hfffe, 1);
        wreg(EDSP_OFF_WPAGE, 16'h0002);
        wp = 2;
        acc(1'b1, 1'b0, 16'h8000, 1);
        rreg(EDSP_OFF_STAT, 16'h0003);
        wreg(EDSP_OFF_MASK, 16'h0002);
        @(posedge clock);
        `CHK(irq, 1'b1)
        finish_test;
    end
endmodule
`default_nettype wire
